// ===== hdl/adc_cfg_pkg.sv
// Purpose: Shared constants and carriers for the converter configuration bank
// Assumes: APB with 32-bit data, 16-bit registers in the low half of each word
// Notes: Printed offsets are register indices; byte address is four times index
package adc_cfg_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 16;
  localparam int unsigned NUM_REGS = 5;
  // Register indices
  localparam logic [9:0] IDX_PWR_AVG = 10'h0c4;
  localparam logic [9:0] IDX_LANE_CLK = 10'h0c5;
  localparam logic [9:0] IDX_START_A = 10'h0f4;
  localparam logic [9:0] IDX_START_B = 10'h0f6;
  localparam logic [9:0] IDX_DOWNCONV = 10'h0fb;
  // Own register holding the output data-rate select
  localparam logic [9:0] IDX_DATA_RATE = 10'h0c1;
  // Slot numbers inside the register memory
  localparam logic [2:0] SLOT_PWR_AVG = 3'h0;
  localparam logic [2:0] SLOT_LANE_CLK = 3'h1;
  localparam logic [2:0] SLOT_START_A = 3'h2;
  localparam logic [2:0] SLOT_START_B = 3'h3;
  localparam logic [2:0] SLOT_DOWNCONV = 3'h4;
  localparam logic [2:0] SLOT_DATA_RATE = 3'h5;
  localparam logic [2:0] SLOT_NONE = 3'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Field positions
  localparam int unsigned POS_FULL_PD = 0;
  localparam int unsigned POS_AVG_C = 1;
  localparam int unsigned POS_AVG_B = 4;
  localparam int unsigned POS_SLOW_CLK = 2;
  localparam int unsigned POS_LANE_C = 9;
  localparam int unsigned POS_START = 1;
  localparam int unsigned POS_DC_EN = 0;
  localparam int unsigned POS_LANE_E = 1;
  localparam int unsigned POS_XOR_SRC = 2;
  localparam int unsigned POS_SYNC_MODE = 3;
  localparam int unsigned POS_DATA_RATE = 8;
  localparam int unsigned POS_XOR_EN = 9;

  typedef struct packed {
    logic full_power_down;
    logic [1:0] averaging_setup_b;
    logic averaging_setup_c;
    logic lane_timing_cfg_c;
    logic [1:0] slow_variant_clock_cfg;
    logic startup_step_a;
    logic startup_step_b;
    logic oscillator_sync_mode;
    logic xor_source;
    logic lane_timing_cfg_e;
    logic downconvert_enable;
    logic single_data_rate;
    logic xor_enable;
  } cfg_t;

  typedef struct packed {
    logic [17:0] sample;
    logic prbs_bit;
  } sample_t;
endpackage : adc_cfg_pkg

// ===== hdl/cfg_reg_mem.sv
// Purpose: Small register memory for the configuration bank
// Assumes: One write port, one registered read port
// Notes: Every word resets to zero so the chip starts powered up and idle
`timescale 1ns/100ps
module cfg_reg_mem #(
  parameter int unsigned DEPTH = 6,
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o,
  output logic [DEPTH*WIDTH-1:0] all_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [WIDTH-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
      if (we_i && waddr_i == 3'(i)) begin
        mem_d[i] = wdata_i;
      end
      if (raddr_i == 3'(i)) begin
        rdata_d = mem_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n_i) begin
        mem_q[i] <= adc_cfg_pkg::REG_RESET;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_o[i*WIDTH +: WIDTH] = mem_q[i];
    end
  end
endmodule : cfg_reg_mem

// ===== hdl/adc_config_register_set.sv
// Purpose: APB configuration bank steering power, output scrambling and down conversion
// Assumes: Sample data shares the bank clock; the sync pin may be asynchronous and passes two flops
// Notes: Averaging, lane and startup fields are stored and exported only
//
// Notes on behaviour
// - Full power-down bit 1 powers the whole chip down; 0 runs normally.
// - With the down-converter enabled, sync mode 0 syncs oscillator on each pulse; 1 only the first.
// - Scramble source 0 appends random bit after LSB and XORs with it.
// - Scramble source 1 XORs output data with the conversion LSB.
// - Down-converter enable 1 runs the converter, 0 bypasses it.
// - All fields reset to zero.
// - Data rate bit 0 selects DDR output, 1 selects SDR.
`timescale 1ns/100ps
module adc_config_register_set (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_sync_pin_i,
  input wire logic sample_valid_i,
  input wire adc_cfg_pkg::sample_t sample_i,
  output logic [18:0] data_out_o,
  output logic data_out_valid_o,
  output logic chip_power_down_o,
  output logic oscillator_sync_o,
  output logic downconvert_enable_o,
  output logic single_data_rate_o,
  output adc_cfg_pkg::cfg_t cfg_o
);
  localparam int unsigned DEPTH = 6;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] slot_of(input logic [adc_cfg_pkg::ADDR_W-1:0] a);
    logic [9:0] idx;
    idx = a[11:2];
    if (a[1:0] != 2'h0) begin
      slot_of = adc_cfg_pkg::SLOT_NONE;
    end else begin
      case (idx)
        adc_cfg_pkg::IDX_PWR_AVG: slot_of = adc_cfg_pkg::SLOT_PWR_AVG;
        adc_cfg_pkg::IDX_LANE_CLK: slot_of = adc_cfg_pkg::SLOT_LANE_CLK;
        adc_cfg_pkg::IDX_START_A: slot_of = adc_cfg_pkg::SLOT_START_A;
        adc_cfg_pkg::IDX_START_B: slot_of = adc_cfg_pkg::SLOT_START_B;
        adc_cfg_pkg::IDX_DOWNCONV: slot_of = adc_cfg_pkg::SLOT_DOWNCONV;
        adc_cfg_pkg::IDX_DATA_RATE: slot_of = adc_cfg_pkg::SLOT_DATA_RATE;
        default: slot_of = adc_cfg_pkg::SLOT_NONE;
      endcase
    end
  endfunction : slot_of

  logic [2:0] slot;
  logic access;
  logic done_q;
  logic done_d;
  logic err_q;
  logic err_d;
  logic we;
  logic [15:0] wword;
  logic [15:0] rword;
  logic [15:0] cur_word;
  logic [DEPTH*16-1:0] regs;

  assign slot = slot_of(paddr);
  // Access phase answered one cycle after it starts: pready at second access cycle
  assign access = psel && penable && !done_q;

  always_comb begin
    done_d = access;
    err_d = access && slot == adc_cfg_pkg::SLOT_NONE;
    // Only writes strobing both low byte lanes (pstrb[1:0]) are taken so a register never holds a half update
    we = access && pwrite && slot != adc_cfg_pkg::SLOT_NONE && pstrb[1:0] == 2'h3;
    cur_word = regs[16*32'(slot == adc_cfg_pkg::SLOT_NONE ? 3'h0 : slot) +: 16];
    wword = pwdata[15:0];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= done_d;
      err_q <= err_d;
    end
  end

  cfg_reg_mem #(.DEPTH(DEPTH), .WIDTH(16)) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(we),
    .waddr_i(slot),
    .wdata_i(wword),
    .raddr_i(slot),
    .rdata_o(rword),
    .all_o(regs)
  );

  assign pready = done_q;
  assign pslverr = err_q;
  assign prdata = {16'h0000, rword};

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [15:0] r_pa;
  logic [15:0] r_lc;
  logic [15:0] r_sa;
  logic [15:0] r_sb;
  logic [15:0] r_dc;
  logic [15:0] r_dr;
  adc_cfg_pkg::cfg_t cfg_d;
  adc_cfg_pkg::cfg_t cfg_q;

  always_comb begin
    r_pa = regs[16*adc_cfg_pkg::SLOT_PWR_AVG +: 16];
    r_lc = regs[16*adc_cfg_pkg::SLOT_LANE_CLK +: 16];
    r_sa = regs[16*adc_cfg_pkg::SLOT_START_A +: 16];
    r_sb = regs[16*adc_cfg_pkg::SLOT_START_B +: 16];
    r_dc = regs[16*adc_cfg_pkg::SLOT_DOWNCONV +: 16];
    r_dr = regs[16*adc_cfg_pkg::SLOT_DATA_RATE +: 16];
    cfg_d.full_power_down = r_pa[adc_cfg_pkg::POS_FULL_PD];
    cfg_d.averaging_setup_b = r_pa[adc_cfg_pkg::POS_AVG_B +: 2];
    cfg_d.averaging_setup_c = r_pa[adc_cfg_pkg::POS_AVG_C];
    cfg_d.lane_timing_cfg_c = r_lc[adc_cfg_pkg::POS_LANE_C];
    cfg_d.slow_variant_clock_cfg = r_lc[adc_cfg_pkg::POS_SLOW_CLK +: 2];
    cfg_d.startup_step_a = r_sa[adc_cfg_pkg::POS_START];
    cfg_d.startup_step_b = r_sb[adc_cfg_pkg::POS_START];
    cfg_d.oscillator_sync_mode = r_dc[adc_cfg_pkg::POS_SYNC_MODE];
    cfg_d.xor_source = r_dc[adc_cfg_pkg::POS_XOR_SRC];
    cfg_d.lane_timing_cfg_e = r_dc[adc_cfg_pkg::POS_LANE_E];
    cfg_d.downconvert_enable = r_dc[adc_cfg_pkg::POS_DC_EN];
    cfg_d.single_data_rate = r_dr[adc_cfg_pkg::POS_DATA_RATE];
    cfg_d.xor_enable = r_dr[adc_cfg_pkg::POS_XOR_EN];
  end

  // ----------------------------------------------------------------
  // Sync pulse handling and output scrambling
  // ----------------------------------------------------------------
  logic sync_meta_q;
  logic sync_q;
  logic sync_prev_q;
  logic synced_once_q;
  logic synced_once_d;
  logic osc_sync_d;
  logic osc_sync_q;
  logic sync_edge;
  logic [18:0] out_d;
  logic [18:0] out_q;
  logic out_valid_d;
  logic out_valid_q;
  logic xbit;

  assign sync_edge = sync_q && !sync_prev_q;

  always_comb begin
    synced_once_d = synced_once_q;
    osc_sync_d = 1'b0;
    if (!cfg_q.oscillator_sync_mode) begin
      osc_sync_d = sync_edge;
      synced_once_d = 1'b0;
    end else if (sync_edge && !synced_once_q) begin
      osc_sync_d = 1'b1;
      synced_once_d = 1'b1;
    end
    if (!cfg_q.downconvert_enable || cfg_q.full_power_down) begin
      osc_sync_d = 1'b0;
    end
    xbit = cfg_q.xor_source ? sample_i.sample[0] : sample_i.prbs_bit;
    out_d = {sample_i.sample, 1'b0};
    if (cfg_q.xor_enable) begin
      if (cfg_q.xor_source) begin
        out_d = {sample_i.sample ^ {18{xbit}}, 1'b0};
      end else begin
        out_d = {sample_i.sample ^ {18{xbit}}, xbit};
      end
    end
    out_valid_d = sample_valid_i && !cfg_q.full_power_down;
    if (cfg_q.full_power_down) begin
      out_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
      synced_once_q <= 1'b0;
      osc_sync_q <= 1'b0;
      out_q <= '0;
      out_valid_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      sync_meta_q <= sample_sync_pin_i;
      sync_q <= sync_meta_q;
      sync_prev_q <= sync_q;
      synced_once_q <= synced_once_d;
      osc_sync_q <= osc_sync_d;
      out_q <= out_d;
      out_valid_q <= out_valid_d;
      cfg_q <= cfg_d;
    end
  end

  assign cfg_o = cfg_q;
  assign chip_power_down_o = cfg_q.full_power_down;
  assign downconvert_enable_o = cfg_q.downconvert_enable;
  assign single_data_rate_o = cfg_q.single_data_rate;
  assign oscillator_sync_o = osc_sync_q;
  assign data_out_o = out_q;
  assign data_out_valid_o = out_valid_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_pd_follows_reg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 chip_power_down_o == $past(r_pa[0]))
    else $error("power-down output does not follow register");
  chk_pd_blocks_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_q.full_power_down |=> !data_out_valid_o)
    else $error("data valid while powered down");
  chk_sync_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sync_edge && !cfg_q.oscillator_sync_mode && cfg_q.downconvert_enable
     && !cfg_q.full_power_down) |=> oscillator_sync_o)
    else $error("single pulse did not sync oscillator");
  chk_sync_first_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_q.oscillator_sync_mode && synced_once_q) |=> !oscillator_sync_o)
    else $error("periodic mode synced on a later pulse");
  chk_xor_prbs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_q.xor_enable && !cfg_q.xor_source && !cfg_q.full_power_down) |=>
    data_out_o == {$past(sample_i.sample) ^ {18{$past(sample_i.prbs_bit)}},
                   $past(sample_i.prbs_bit)})
    else $error("random-bit scramble wrong");
  chk_xor_lsb: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (cfg_q.xor_enable && cfg_q.xor_source && !cfg_q.full_power_down) |=>
    data_out_o[18:1] == ($past(sample_i.sample) ^ {18{$past(sample_i.sample[0])}}))
    else $error("lsb scramble wrong");
  chk_dc_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 downconvert_enable_o == $past(r_dc[0]))
    else $error("down-converter enable does not follow register");
  chk_rate_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 single_data_rate_o == $past(r_dr[8]))
    else $error("data rate select does not follow register");
  chk_reset_zero: assert property (@(posedge clk_i)
    !rst_n_i |=> (cfg_o == '0 && regs == '0))
    else $error("fields not zero after reset");
  chk_write_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    we |=> cur_word == $past(wword) || $past(slot) != slot)
    else $error("register did not take written word");
endmodule : adc_config_register_set

// ===== tb/adc_config_register_set_tb_top.sv
// Purpose: Self-checking bench for the converter configuration bank
// Assumes: Field outputs follow registers a cycle later; APB waits end only at the timeout
// Notes: Random data comes from a fixed-seed shift register, mixed with corner cases
`timescale 1ns/100ps
module adc_config_register_set_tb_top;
  logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic sync_pin, svalid, dvalid, pd_o, osync, dc_o, sdr_o, err;
  adc_cfg_pkg::sample_t smp;
  logic [18:0] dout;
  adc_cfg_pkg::cfg_t cfg;
  logic [15:0] lfsr;
  logic [15:0] sh [6];
  logic [9:0] idx [6];
  int fail_count, num_checks, cycles, syncs;

  adc_config_register_set dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_sync_pin_i(sync_pin),
    .sample_valid_i(svalid), .sample_i(smp), .data_out_o(dout), .data_out_valid_o(dvalid),
    .chip_power_down_o(pd_o), .oscillator_sync_o(osync), .downconvert_enable_o(dc_o),
    .single_data_rate_o(sdr_o), .cfg_o(cfg));

  // ----------------------------------------
  // Clock, timeout and sync pulse counter
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  always @(negedge clk_i) begin
    if (osync === 1'b1) syncs++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nxt

  // Shapes a random word into what a host may write: reserved bits stay zero
  function automatic logic [15:0] legal(input int i, input logic [15:0] r);
    case (i)
      0: return {10'h000, r[1] ? 2'h2 : 2'h0, 2'h0, r[1], r[0]};
      1: return {6'h00, r[9], 5'h00, {2{r[2]}}, 2'h0};
      2: return {14'h0000, r[1], 1'b0};
      3: return {14'h0000, r[1], 1'b0};
      4: return {12'h000, r[3:0]};
      default: return {6'h00, r[9:8], 8'h00};
    endcase
  endfunction : legal

  function automatic adc_cfg_pkg::cfg_t exp_cfg();
    adc_cfg_pkg::cfg_t c;
    c = {sh[0][0], sh[0][5:4], sh[0][1], sh[1][9], sh[1][3:2], sh[2][1], sh[3][1],
         sh[4][3], sh[4][2], sh[4][1], sh[4][0], sh[5][8], sh[5][9]};
    return c;
  endfunction : exp_cfg

  function automatic logic [18:0] exp_dout(input adc_cfg_pkg::sample_t s);
    if (sh[0][0]) return '0;
    if (!sh[5][9]) return {s.sample, 1'b0};
    if (!sh[4][2]) return {s.sample ^ {18{s.prbs_bit}}, s.prbs_bit};
    return {s.sample ^ {18{s.sample[0]}}, 1'b0};
  endfunction : exp_dout

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Holds the request until pready is sampled high, then releases it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] st);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input int i, input logic [15:0] v);
    apb(1'b1, {idx[i], 2'b00}, {16'h0000, v}, 4'hf);
    sh[i] = v;
  endtask : wreg

  task automatic rchk(input int i);
    apb(1'b0, {idx[i], 2'b00}, 32'h0000_0000, 4'hf);
    chk("register", rd, {16'h0000, sh[i]});
    chk("pslverr", 32'(err), 32'h0);
  endtask : rchk

  task automatic outs();
    @(negedge clk_i);
    @(negedge clk_i);
    chk("cfg_o", 32'(cfg), 32'(exp_cfg()));
    chk("power_down", 32'(pd_o), 32'(sh[0][0]));
    chk("dc_enable", 32'(dc_o), 32'(sh[4][0]));
    chk("sdr", 32'(sdr_o), 32'(sh[5][8]));
  endtask : outs

  task automatic samp(input adc_cfg_pkg::sample_t s);
    @(posedge clk_i);
    smp <= s;
    svalid <= 1'b1;
    @(posedge clk_i);
    svalid <= 1'b0;
    @(negedge clk_i);
    chk("data_out", 32'(dout), 32'(exp_dout(s)));
    chk("data_valid", 32'(dvalid), 32'(!sh[0][0]));
  endtask : samp

  task automatic pulses(input int k);
    syncs = 0;
    repeat (k) begin
      @(posedge clk_i) sync_pin <= 1'b1;
      repeat (3) @(posedge clk_i);
      sync_pin <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
  endtask : pulses

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    idx = '{adc_cfg_pkg::IDX_PWR_AVG, adc_cfg_pkg::IDX_LANE_CLK, adc_cfg_pkg::IDX_START_A,
            adc_cfg_pkg::IDX_START_B, adc_cfg_pkg::IDX_DOWNCONV, adc_cfg_pkg::IDX_DATA_RATE};
    {rst_n_i, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {sync_pin, svalid, smp} = '0;
    sh = '{default: 16'h0000};
    lfsr = 16'hda2d;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    outs();
    for (int i = 0; i < 6; i++) rchk(i);
    repeat (3) begin
      for (int i = 0; i < 6; i++) begin
        lfsr = nxt(lfsr);
        wreg(i, legal(i, lfsr));
      end
      for (int i = 0; i < 6; i++) rchk(i);
      outs();
    end
    // Reset again with nonzero contents: every word and field must clear
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    sh = '{default: 16'h0000};
    outs();
    for (int i = 0; i < 6; i++) rchk(i);
    // Partial strobes must leave the word untouched without an error
    apb(1'b1, {idx[1], 2'b00}, {16'h0000, sh[1] ^ 16'h0200}, 4'h1);
    chk("partial_err", 32'(err), 32'h0);
    rchk(1);
    apb(1'b0, 12'h000, 32'h0000_0000, 4'hf);
    chk("unmapped_err", 32'(err), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    wreg(0, 16'h0000);
    for (int m = 0; m < 3; m++) begin
      wreg(5, (m == 0) ? 16'h0000 : 16'h0200);
      wreg(4, (m == 2) ? 16'h0005 : 16'h0001);
      samp('1);
      samp(19'h00001);
      repeat (4) begin
        lfsr = nxt(lfsr);
        samp({lfsr, lfsr[15:13]});
      end
    end
    wreg(0, 16'h0001);
    outs();
    samp({lfsr, 3'h5});
    wreg(0, 16'h0000);
    wreg(4, 16'h0001);
    pulses(2);
    chk("sync_single", 32'(syncs), 32'd2);
    wreg(4, 16'h0009);
    pulses(3);
    chk("sync_periodic", 32'(syncs), 32'd1);
    conclude();
  end
endmodule : adc_config_register_set_tb_top
